//--- pkg/nvac_map.svh
// Constants for the byte store access controller: offsets, fields, resets.
// Assumes inclusion by bare name from the package and the design module.
//
// Overview of operation
// RULE1: Sixty-four byte cells, reached only through index, byte and control registers.
// RULE2: Index register holds six bits, upper two read zero, resets to zero.
// RULE3: Byte register is a full eight-bit read/write register resetting to zero.
// RULE4: Software sets pointer one to 40h and bank select to 01h first.
// RULE5: Program permit, control bit 3, must be one before any write starts.
// RULE6: Program start, bit 2, starts a write only with permit; hardware clears it.
// RULE7: Fetch permit, control bit 1, must be one before any read starts.
// RULE8: Fetch start, bit 0, starts a read only with permit; hardware clears it.
// RULE9: Software never sets both start flags, nor all four bits, at once.
// RULE10: Fetched byte lands in byte register and stays until next operation.
// RULE11: Software loads index and byte, then permit, then start next instruction.
// RULE12: Software clears global interrupt enable around the start of a write.
// RULE13: Write cycles are timed by a timer asynchronous to the system clock.
// RULE14: Power-on clears the program permit so no write occurs unasked.
// RULE15: End of a write cycle sets the write-done request flag.
// RULE16: Software sets write-done enable before completion can interrupt.
// RULE17: Flag, both enables and stack not full branch to write-done vector.
// RULE18: Servicing the write-done interrupt clears its request flag automatically.
// RULE19: Bank bit 0 picks bank; direct access always reaches bank 0.
// RULE20: Software keeps the device awake until store operations finish.
// RULE21: Start attempts during an active cycle are ignored until its flag clears.
`ifndef NVAC_MAP_SVH
`define NVAC_MAP_SVH

`define NVAC_DEPTH          64
`define NVAC_CTRL_OFFSET    8'h40
`define NVAC_CTRL_BANK      1'b1
`define NVAC_BIT_PROG_PERM  3
`define NVAC_BIT_PROG_GO    2
`define NVAC_BIT_FETCH_PERM 1
`define NVAC_BIT_FETCH_GO   0
`define NVAC_INDEX_RESET    6'h00
`define NVAC_BYTE_RESET     8'h00
`define NVAC_CTRL_RESET     4'h0
`define NVAC_FETCH_CYCLES   4'h2

`endif

//--- pkg/nvac_pkg.sv
// Types shared by the byte store access controller.
// Assumes the constants header sits on the include path.
`include "nvac_map.svh"
package nvac_pkg;

    typedef enum logic [1:0] {
        NVAC_IDLE,
        NVAC_FETCH,
        NVAC_PROG
    } nvac_state_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       bank;
        logic [7:0] addr;
        logic [7:0] wdata;
    } nvac_sfr_req_t;

    typedef struct packed {
        logic prog_perm;
        logic prog_go;
        logic fetch_perm;
        logic fetch_go;
    } nvac_ctrl_t;

endpackage

//--- verif/nvac_ctrl_monitor.sv
// Port checker for the byte store access controller.
// Assumes it is bound to every instance of nvac_ctrl.
`timescale 1ns/1ps
module nvac_ctrl_monitor
    import nvac_pkg::*;
(
    // Clock, reset and core side.
    input wire logic          clk,
    input wire logic          rstn,
    input wire nvac_sfr_req_t sfr_req,
    input wire logic          sel_index,
    input wire logic    [7:0] sfr_rdata,
    // Timer, interrupt and status.
    input wire logic          timer_done,
    input wire logic          timer_start,
    input wire logic          nv_done_irq_enable,
    input wire logic          global_irq_enable,
    input wire logic          stack_full,
    input wire logic          irq_service,
    input wire logic          nv_done_irq_flag,
    input wire logic          irq_branch,
    input wire logic          busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////
    sequence s_prog_wr;
        sfr_req.wr && sfr_req.bank && sfr_req.addr == 8'h40 && sfr_req.wdata[2];
    endsequence
    sequence s_fetch_run;
        busy [*3] ##1 !busy;
    endsequence
    property p_go; timer_start |-> s_prog_wr; endproperty
    property p_idle; timer_start |-> !busy; endproperty
    property p_run; timer_start |=> busy; endproperty
    property p_fetch; $rose(busy) && !$past(timer_start) |-> s_fetch_run; endproperty
    property p_set; timer_done && busy |=> nv_done_irq_flag; endproperty
    property p_hold; nv_done_irq_flag && !irq_service |=> nv_done_irq_flag;
    endproperty
    property p_clr; irq_service && !timer_done |=> !nv_done_irq_flag; endproperty
    property p_branch; irq_branch == (nv_done_irq_flag && nv_done_irq_enable
        && global_irq_enable && !stack_full); endproperty
    property p_idx; sfr_req.rd && sel_index |-> sfr_rdata[7:6] == 2'b00;
    endproperty
    a_go: assert property (p_go) else $error("write start without request");
    a_idle: assert property (p_idle) else $error("start while busy");
    a_run: assert property (p_run) else $error("write not running");
    a_fetch: assert property (p_fetch) else $error("fetch length off");
    a_set: assert property (p_set) else $error("done flag not set");
    a_hold: assert property (p_hold) else $error("done flag lost");
    a_clr: assert property (p_clr) else $error("done flag not cleared");
    a_branch: assert property (p_branch) else $error("branch wrong");
    a_idx: assert property (p_idx) else $error("index top bits set");
endmodule
bind nvac_ctrl nvac_ctrl_monitor u_mon (.clk(clk), .rstn(rstn),
    .sfr_req(sfr_req), .sel_index(sel_index), .sfr_rdata(sfr_rdata),
    .timer_done(timer_done), .timer_start(timer_start),
    .nv_done_irq_enable(nv_done_irq_enable),
    .global_irq_enable(global_irq_enable), .stack_full(stack_full),
    .irq_service(irq_service), .nv_done_irq_flag(nv_done_irq_flag),
    .irq_branch(irq_branch), .busy(busy));

//--- verif/nvac_ctrl_tb_top.sv
// Self-checking bench for the byte store access controller.
// Assumes the package, header and checker are compiled first.
`timescale 1ns/1ps
module nvac_ctrl_tb_top
    import nvac_pkg::*;
;
    logic          clk = 0;
    logic          rstn = 0;
    nvac_sfr_req_t req = '0;
    logic          s_idx = 0, s_byt = 0, t_done = 0, svc = 0;
    logic    [2:0] en = 3'h0;
    logic    [7:0] rdata, adr[4], dat[4], q[$];
    logic          t_start, flag, branch, busy;
    int            miscompares = 0, n_checks = 0, n_start = 0;
    always #12.5 clk = ~clk;
    nvac_ctrl dut (.clk(clk), .rstn(rstn), .sfr_req(req), .sel_index(s_idx),
        .sel_byte(s_byt), .sfr_rdata(rdata), .timer_done(t_done),
        .timer_start(t_start), .nv_done_irq_enable(en[0]),
        .global_irq_enable(en[1]), .stack_full(en[2]), .irq_service(svc),
        .nv_done_irq_flag(flag), .irq_branch(branch), .busy(busy));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Target 0 index, 1 byte, 2 control; a read notes d as the expectation.
    task automatic acc(logic w, logic [1:0] s, logic [7:0] d);
        @(posedge clk);
        if (!w) q.push_back(d);
        req <= '{wr: w, rd: !w, bank: s[1], addr: 8'h40, wdata: d};
        s_idx <= (s == 2'd0);
        s_byt <= (s == 2'd1);
        @(posedge clk);
        req <= '0;
        s_idx <= 1'b0;
        s_byt <= 1'b0;
    endtask
    // Read data is combinational, so it is judged mid-cycle once settled.
    always @(negedge clk) begin
        if (req.rd) chk("rdata", q.pop_front(), rdata);
    end
    always @(posedge clk) begin
        if (t_start) n_start++;
    end
    initial begin
        #100000;
        miscompares++;
        end_sim();
    end
    initial begin
        void'($urandom(75));
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        acc(0, 0, 8'h00);
        acc(0, 1, 8'h00);
        acc(0, 2, 8'h00);
        acc(1, 0, 8'hff);
        acc(0, 0, 8'h3f);
        acc(1, 2, 8'h04);
        acc(1, 2, 8'h01);
        acc(0, 2, 8'h00);
        chk("starts", 0, 8'(n_start));
        chk("busy", 0, {7'h0, busy});
        for (int i = 0; i < 4; i++) begin
            adr[i] = 8'(i * 16 + $urandom_range(15));
            dat[i] = 8'($urandom);
            acc(1, 0, adr[i]);
            acc(1, 1, dat[i]);
            acc(0, 1, dat[i]);
            en <= {1'($urandom), 2'b01};
            acc(1, 2, 8'h0a);
            acc(1, 2, 8'h0e);
            en[1] <= 1'b1;
            acc(1, 2, 8'h0b);
            acc(0, 2, 8'h0e);
            repeat ($urandom_range(20)) @(posedge clk);
            t_done <= 1'b1;
            svc <= i[0];
            @(posedge clk);
            t_done <= 1'b0;
            svc <= 1'b0;
            acc(0, 2, 8'h0a);
            chk("flag", 1, {7'h0, flag});
            chk("branch", {7'h0, !en[2]}, {7'h0, branch});
            svc <= 1'b1;
            @(posedge clk);
            svc <= 1'b0;
            @(posedge clk);
            chk("flag", 0, {7'h0, flag});
        end
        chk("starts", 4, 8'(n_start));
        for (int i = 0; i < 4; i++) begin
            acc(1, 0, adr[i]);
            acc(1, 2, 8'h0b);
            @(posedge clk);
            for (int k = 0; k < 50 && busy !== 1'b0; k++) @(posedge clk);
            acc(0, 1, dat[i]);
            acc(1, 0, adr[i] ^ 8'h01);
            acc(0, 1, dat[i]);
            acc(0, 2, 8'h0a);
        end
        end_sim();
    end
endmodule

//--- verilog/nvac_ctrl.sv
// Byte store access controller with its index, byte and control registers.
// Assumes the core decodes index and byte register selects itself, and
// presents bank-1 indirect accesses with the bank bit already applied.
`timescale 1ns/1ps
`include "nvac_map.svh"
module nvac_ctrl
    import nvac_pkg::*;
(
    // Clock and reset.
    input  wire logic          clk,
    input  wire logic          rstn,
    // Special register access from the core.
    input  wire nvac_sfr_req_t sfr_req,
    input  wire logic          sel_index,
    input  wire logic          sel_byte,
    output logic        [7:0]  sfr_rdata,
    // Write timer, asynchronous to clk, already synchronised.
    input  wire logic          timer_done,
    output logic               timer_start,
    // Interrupt hand-off with the core's controller.
    input  wire logic          nv_done_irq_enable,
    input  wire logic          global_irq_enable,
    input  wire logic          stack_full,
    input  wire logic          irq_service,
    output logic               nv_done_irq_flag,
    output logic               irq_branch,
    // Status.
    output logic               busy
);

////////////////////////////////////////////////////////////////////////////////

    logic [7:0]  cell_mem [`NVAC_DEPTH];
    logic [5:0]  nv_cell_index;
    logic [7:0]  nv_byte_buffer;
    nvac_ctrl_t  nv_control;
    nvac_state_t state;
    logic [3:0]  fetch_cnt;
    logic        program_permit;
    logic        prog_go;
    logic        fetch_permit;
    logic        fetch_go;
    logic [`NVAC_DEPTH-1:0] cell_we;

    localparam nvac_ctrl_t ctrl_rst = `NVAC_CTRL_RESET;

    function automatic logic is_ctrl(input nvac_sfr_req_t r);
        return r.bank == `NVAC_CTRL_BANK && r.addr == `NVAC_CTRL_OFFSET;
    endfunction

    // Unimplemented upper bits of the control register read as zero.
    function automatic logic [7:0] ctrl_readback(input nvac_ctrl_t c);
        return {4'h0, c};
    endfunction

    logic ctrl_wr;
    logic idx_wr;
    logic byte_wr;
    logic start_fetch;
    logic start_prog;
    logic fetch_end;
    logic prog_end;

    // Direct selects are gated to bank 0 by the core; only control is banked.
    assign ctrl_wr = sfr_req.wr && is_ctrl(sfr_req); // RULE19
    assign idx_wr  = sfr_req.wr && sel_index;
    assign byte_wr = sfr_req.wr && sel_byte;

    // A start needs its permit already set; writing both in one access is
    // not allowed to software, so the stored permit is what counts.
    assign start_prog  = ctrl_wr && state == NVAC_IDLE && nv_control.prog_perm
                         && sfr_req.wdata[`NVAC_BIT_PROG_GO]; // RULE5 RULE6 RULE21
    assign start_fetch = ctrl_wr && state == NVAC_IDLE && nv_control.fetch_perm
                         && sfr_req.wdata[`NVAC_BIT_FETCH_GO]
                         && !start_prog; // RULE7 RULE8 RULE21
    assign fetch_end = state == NVAC_FETCH && fetch_cnt == 4'h0;
    assign prog_end  = state == NVAC_PROG && timer_done; // RULE13

////////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state <= NVAC_IDLE;
        end else begin
            case (state)
                NVAC_IDLE: begin
                    if (start_prog) begin
                        state <= NVAC_PROG;
                    end else if (start_fetch) begin
                        state <= NVAC_FETCH;
                    end
                end
                NVAC_FETCH: begin
                    if (fetch_end) begin
                        state <= NVAC_IDLE;
                    end
                end
                NVAC_PROG: begin
                    if (prog_end) begin
                        state <= NVAC_IDLE;
                    end
                end
                default: begin
                    state <= NVAC_IDLE;
                end
            endcase
        end
    end

    // A fetch takes a fixed count of clocks; only a write waits on the timer.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            fetch_cnt <= 4'h0;
        end else if (start_fetch) begin
            fetch_cnt <= `NVAC_FETCH_CYCLES;
        end else if (state == NVAC_FETCH && fetch_cnt != 4'h0) begin
            fetch_cnt <= fetch_cnt - 4'h1;
        end
    end

    // The timer runs on its own oscillator; a one-cycle start pulse kicks it.
    assign timer_start = start_prog; // RULE13
    assign busy        = state != NVAC_IDLE;

////////////////////////////////////////////////////////////////////////////////

    // Permits follow every control write, whatever the cycle state.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            program_permit <= ctrl_rst.prog_perm; // RULE14
            fetch_permit   <= ctrl_rst.fetch_perm;
        end else if (ctrl_wr) begin
            program_permit <= sfr_req.wdata[`NVAC_BIT_PROG_PERM]; // RULE5
            fetch_permit   <= sfr_req.wdata[`NVAC_BIT_FETCH_PERM]; // RULE7
        end
    end

    // Go flags only rise on an accepted start and fall at cycle end, so
    // software can neither clear one nor raise it without its permit.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            prog_go <= ctrl_rst.prog_go;
        end else if (start_prog) begin
            prog_go <= 1'b1; // RULE6
        end else if (prog_end) begin
            prog_go <= 1'b0; // RULE6
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            fetch_go <= ctrl_rst.fetch_go;
        end else if (start_fetch) begin
            fetch_go <= 1'b1; // RULE8
        end else if (fetch_end) begin
            fetch_go <= 1'b0; // RULE8
        end
    end

    assign nv_control = '{prog_perm:  program_permit,
                          prog_go:    prog_go,
                          fetch_perm: fetch_permit,
                          fetch_go:   fetch_go};

    always_ff @(posedge clk) begin
        if (!rstn) begin
            nv_cell_index <= `NVAC_INDEX_RESET; // RULE2
        end else if (idx_wr) begin
            nv_cell_index <= sfr_req.wdata[5:0]; // RULE2
        end
    end

    // A completing fetch beats a software write to the byte register.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            nv_byte_buffer <= `NVAC_BYTE_RESET; // RULE3
        end else if (fetch_end) begin
            nv_byte_buffer <= cell_mem[nv_cell_index]; // RULE10
        end else if (byte_wr) begin
            nv_byte_buffer <= sfr_req.wdata; // RULE3
        end
    end

    // One strobe per cell, decoded from the index at the end of a write.
    for (genvar k = 0; k < `NVAC_DEPTH; k++) begin : g_cell_we
        assign cell_we[k] = prog_end && nv_cell_index == 6'(k);
    end

    // Cell contents survive reset, as the store is non-volatile.
    always_ff @(posedge clk) begin
        for (int k = 0; k < `NVAC_DEPTH; k++) begin
            if (cell_we[k]) begin
                cell_mem[k] <= nv_byte_buffer; // RULE1
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////

    // Set wins over the service clear in the same cycle.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            nv_done_irq_flag <= 1'b0;
        end else if (prog_end) begin
            nv_done_irq_flag <= 1'b1; // RULE15
        end else if (irq_service) begin
            nv_done_irq_flag <= 1'b0; // RULE18
        end
    end

    // The branch request is a level; the core chooses when to act on it.
    assign irq_branch = nv_done_irq_flag && nv_done_irq_enable
                        && global_irq_enable && !stack_full; // RULE17

    // An access that selects nothing reads back zero.
    always_comb begin
        sfr_rdata = 8'h00;
        if (sfr_req.rd && is_ctrl(sfr_req)) begin
            sfr_rdata = ctrl_readback(nv_control);
        end else if (sfr_req.rd && sel_index) begin
            sfr_rdata = {2'b00, nv_cell_index}; // RULE2
        end else if (sfr_req.rd && sel_byte) begin
            sfr_rdata = nv_byte_buffer;
        end
    end

endmodule
